//--- src/dscm_top.sv
`timescale 1ns/1ps
// Summary of operation
// - The speed reference is a 16-bit signed word, 0 to +/-32767 = 200%.
// - Reference 0..16384 maps linearly onto 0..100% of min..max reference.
// - A two's complement negative reference reverses the rotation.
// - Output frequency returns as a signed word, 16384 = 100% of lo..hi.
// - Station address range follows protocol; default address is 1.
// - Station address and baud rate cannot be written over the link.
// - Baud code 0..5 selects 300..9600 bit/s, default 5 (9600).
// - Coast source select codes 0..3 (input, serial, and, or), default 3.
// - Coast input and control bit 3 are active low (0 = coast).
// - Serial mode follows only the bit; input mode follows only the pin.
// - And mode coasts only when both are 0.
// - Or mode runs only when both are 1.
module dscm_top
   import dscm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic coast_in_n,
   input wire logic local_set,
   input wire logic [1:0] local_protocol,
   input wire logic [7:0] local_station,
   input wire logic [2:0] local_baud,
   input wire logic [15:0] act_freq,
   input wire logic act_reverse,
   output logic motor_run,
   output logic [18:0] ref_value,
   output logic ref_reverse,
   output logic [1:0] protocol,
   output logic [7:0] station_addr,
   output logic [2:0] baud_code,
   output logic [15:0] baud_div,
   output logic local_reject
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic awready_q, awready_d, wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic arready_q, arready_d, rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [15:0] ctrl_q, ctrl_d, sref_q, sref_d;
   logic [15:0] rmin_q, rmin_d, rmax_q, rmax_d;
   logic [15:0] flo_q, flo_d, fhi_q, fhi_d;
   dscm_coast_e csel_q, csel_d;
   logic [1:0] proto_q, proto_d;
   logic [7:0] stn_q, stn_d;
   logic [2:0] baud_q, baud_d;
   logic [15:0] bdiv_q, bdiv_d;
   logic rej_q, rej_d;
   logic din_q, din_d, run_q, run_d;
   logic [18:0] rval_q, rval_d;
   logic rrev_q, rrev_d;
   logic start_q, start_d, frev_q, frev_d, fzero_q, fzero_d;
   logic [15:0] fword_q, fword_d;
   logic [31:0] wmask;
   logic [7:0] wa, ra, amax;
   logic addr_ok;
   logic [15:0] rdiff, rmag;
   logic [31:0] rprod;

   dscm_div_if div ();

   dscm_divider u_div (
      .ref_clk (ref_clk),
      .resetn (resetn),
      .div (div)
   );

   // ------------------------------------------------------------
   // Register bus, write side
   // ------------------------------------------------------------
   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      ctrl_d = ctrl_q;
      sref_d = sref_q;
      rmin_d = rmin_q;
      rmax_d = rmax_q;
      flo_d = flo_q;
      fhi_d = fhi_q;
      csel_d = csel_q;
      wa = {awaddr_q[7:2], 2'b00};
      for (int i = 0; i < 4; i++) begin
         wmask[8*i +: 8] = {8{wstrb_q[i]}};
      end
      if (s_axi_awvalid && awready_q) begin
         aw_have_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (aw_have_q && w_have_q && !bvalid_q) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = RESP_OKAY;
         if (wa == OFF_CTRL) begin
            ctrl_d = (ctrl_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
         end else if (wa == OFF_SPEED_REF) begin
            sref_d = (sref_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
         end else if (wa == OFF_REF_MIN) begin
            rmin_d = (rmin_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
         end else if (wa == OFF_REF_MAX) begin
            rmax_d = (rmax_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
         end else if (wa == OFF_FREQ_LO) begin
            flo_d = (flo_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
         end else if (wa == OFF_FREQ_HI) begin
            fhi_d = (fhi_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
         end else if (wa == OFF_COAST_SEL) begin
            if (wstrb_q[0]) begin
               csel_d = dscm_coast_e'(wdata_q[1:0]);
            end
         end else if (wa == OFF_STATION || wa == OFF_BAUD) begin
            bresp_d = RESP_SLVERR;
         end else if (wa == OFF_REF_OUT || wa == OFF_FREQ_WORD ||
                      wa == OFF_STATUS) begin
            bresp_d = RESP_SLVERR;
         end else begin
            bresp_d = RESP_DECERR;
         end
      end
      awready_d = !aw_have_d && !bvalid_d;
      wready_d = !w_have_d && !bvalid_d;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         ctrl_q <= CTRL_RST;
         sref_q <= '0;
         rmin_q <= REF_MIN_RST;
         rmax_q <= REF_MAX_RST;
         flo_q <= FREQ_LO_RST;
         fhi_q <= FREQ_HI_RST;
         csel_q <= COAST_SEL_RST;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         ctrl_q <= ctrl_d;
         sref_q <= sref_d;
         rmin_q <= rmin_d;
         rmax_q <= rmax_d;
         flo_q <= flo_d;
         fhi_q <= fhi_d;
         csel_q <= csel_d;
      end
   end

   // ------------------------------------------------------------
   // Register bus, read side
   // ------------------------------------------------------------
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      ra = {s_axi_araddr[7:2], 2'b00};
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = '0;
         if (ra == OFF_CTRL) begin
            rdata_d[15:0] = ctrl_q;
         end else if (ra == OFF_SPEED_REF) begin
            rdata_d[15:0] = sref_q;
         end else if (ra == OFF_REF_MIN) begin
            rdata_d[15:0] = rmin_q;
         end else if (ra == OFF_REF_MAX) begin
            rdata_d[15:0] = rmax_q;
         end else if (ra == OFF_FREQ_LO) begin
            rdata_d[15:0] = flo_q;
         end else if (ra == OFF_FREQ_HI) begin
            rdata_d[15:0] = fhi_q;
         end else if (ra == OFF_COAST_SEL) begin
            rdata_d[1:0] = csel_q;
         end else if (ra == OFF_STATION) begin
            rdata_d[9:0] = {proto_q, stn_q};
         end else if (ra == OFF_BAUD) begin
            rdata_d[2:0] = baud_q;
         end else if (ra == OFF_REF_OUT) begin
            rdata_d = {rrev_q, 12'h000, rval_q};
         end else if (ra == OFF_FREQ_WORD) begin
            rdata_d[15:0] = fword_q;
         end else if (ra == OFF_STATUS) begin
            rdata_d[1:0] = {din_q, run_q};
         end else begin
            rresp_d = RESP_DECERR;
         end
      end
      arready_d = !rvalid_d;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // ------------------------------------------------------------
   // Locally preset link settings
   // ------------------------------------------------------------
   // Whole set is refused if any field is out of range
   always_comb begin
      proto_d = proto_q;
      stn_d = stn_q;
      baud_d = baud_q;
      rej_d = 1'b0;
      addr_ok = 1'b0;
      amax = ADDR_MAX_NATIVE;
      if (local_protocol == PROTO_NATIVE) begin
         addr_ok = (local_station <= ADDR_MAX_NATIVE);
      end else if (local_protocol == PROTO_BUILDING) begin
         amax = ADDR_MAX_BUILDING;
         addr_ok = (local_station != 8'h00) && (local_station <= amax);
      end else if (local_protocol == PROTO_MODBUS) begin
         amax = ADDR_MAX_MODBUS;
         addr_ok = (local_station != 8'h00) && (local_station <= amax);
      end
      if (local_set) begin
         if (addr_ok && local_baud <= BAUD_MAX) begin
            proto_d = local_protocol;
            stn_d = local_station;
            baud_d = local_baud;
         end else begin
            rej_d = 1'b1;
         end
      end
      bdiv_d = 16'(CLK_HZ / BAUD_RATE[baud_q]);
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         proto_q <= PROTO_RST;
         stn_q <= STATION_RST;
         baud_q <= BAUD_RST;
         bdiv_q <= '0;
         rej_q <= 1'b0;
      end else begin
         proto_q <= proto_d;
         stn_q <= stn_d;
         baud_q <= baud_d;
         bdiv_q <= bdiv_d;
         rej_q <= rej_d;
      end
   end

   // ------------------------------------------------------------
   // Coast merge and reference scaling
   // ------------------------------------------------------------
   always_comb begin
      din_d = coast_in_n;
      case (csel_q)
         COAST_DIN: run_d = din_q;
         COAST_SERIAL: run_d = ctrl_q[CTRL_COAST_BIT];
         COAST_AND: run_d = din_q | ctrl_q[CTRL_COAST_BIT];
         default: run_d = din_q & ctrl_q[CTRL_COAST_BIT];
      endcase
      rdiff = (rmax_q > rmin_q) ? rmax_q - rmin_q : 16'h0000;
      rrev_d = sref_q[15];
      rmag = sref_q[15] ? 16'(~sref_q + 16'h0001) : sref_q;
      rprod = rdiff * rmag;
      rval_d = {3'b000, rmin_q} + {1'b0, rprod[31:SCALE_SHIFT]};
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         din_q <= 1'b0;
         run_q <= 1'b0;
         rval_q <= '0;
         rrev_q <= 1'b0;
      end else begin
         din_q <= din_d;
         run_q <= run_d;
         rval_q <= rval_d;
         rrev_q <= rrev_d;
      end
   end

   // ------------------------------------------------------------
   // Output frequency encoding
   // ------------------------------------------------------------
   // Divider is shared over time, so the word lags by about 32 cycles
   always_comb begin
      start_d = 1'b0;
      frev_d = frev_q;
      fzero_d = fzero_q;
      fword_d = fword_q;
      if (!start_q && !div.busy && !div.done) begin
         start_d = 1'b1;
         frev_d = act_reverse;
         fzero_d = (fhi_q <= flo_q) || (act_freq <= flo_q);
      end
      if (div.done) begin
         if (fzero_q) begin
            fword_d = 16'h0000;
         end else if (div.quotient > {14'h0000, WORD_LIMIT}) begin
            fword_d = frev_q ? 16'(~WORD_LIMIT + 16'h0001) : WORD_LIMIT;
         end else if (frev_q) begin
            fword_d = 16'(~div.quotient[15:0] + 16'h0001);
         end else begin
            fword_d = div.quotient[15:0];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         start_q <= 1'b0;
         frev_q <= 1'b0;
         fzero_q <= 1'b1;
         fword_q <= '0;
      end else begin
         start_q <= start_d;
         frev_q <= frev_d;
         fzero_q <= fzero_d;
         fword_q <= fword_d;
      end
   end

   assign div.start = start_q;
   assign div.dividend = {16'(act_freq - flo_q), 14'h0000};
   assign div.divisor = 16'(fhi_q - flo_q);

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign motor_run = run_q;
   assign ref_value = rval_q;
   assign ref_reverse = rrev_q;
   assign protocol = proto_q;
   assign station_addr = stn_q;
   assign baud_code = baud_q;
   assign baud_div = bdiv_q;
   assign local_reject = rej_q;
endmodule

//--- src/dscm_pkg.sv
package dscm_pkg;
   // ------------------------------------------------------------
   // Clock and link rates
   // ------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int BAUD_RATE [0:5] = '{300, 600, 1200, 2400, 4800, 9600};
   localparam logic [2:0] BAUD_MAX = 3'h5;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SPEED_REF = 8'h04;
   localparam logic [7:0] OFF_REF_MIN = 8'h08;
   localparam logic [7:0] OFF_REF_MAX = 8'h0C;
   localparam logic [7:0] OFF_FREQ_LO = 8'h10;
   localparam logic [7:0] OFF_FREQ_HI = 8'h14;
   localparam logic [7:0] OFF_COAST_SEL = 8'h18;
   localparam logic [7:0] OFF_STATION = 8'h1C;
   localparam logic [7:0] OFF_BAUD = 8'h20;
   localparam logic [7:0] OFF_REF_OUT = 8'h24;
   localparam logic [7:0] OFF_FREQ_WORD = 8'h28;
   localparam logic [7:0] OFF_STATUS = 8'h2C;

   // ------------------------------------------------------------
   // Fields, reset values, scaling
   // ------------------------------------------------------------
   localparam int CTRL_COAST_BIT = 3;
   localparam int SCALE_SHIFT = 14;
   localparam logic [15:0] WORD_LIMIT = 16'h7FFF;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] REF_MIN_RST = 16'h0000;
   localparam logic [15:0] REF_MAX_RST = 16'h0032;
   localparam logic [15:0] FREQ_LO_RST = 16'h0000;
   localparam logic [15:0] FREQ_HI_RST = 16'h0032;
   localparam logic [7:0] STATION_RST = 8'h01;
   localparam logic [2:0] BAUD_RST = 3'h5;

   // ------------------------------------------------------------
   // Protocols and address ranges
   // ------------------------------------------------------------
   localparam logic [1:0] PROTO_NATIVE = 2'h0;
   localparam logic [1:0] PROTO_BUILDING = 2'h1;
   localparam logic [1:0] PROTO_MODBUS = 2'h3;
   localparam logic [1:0] PROTO_RST = 2'h0;
   localparam logic [7:0] ADDR_MAX_NATIVE = 8'hF7;
   localparam logic [7:0] ADDR_MAX_BUILDING = 8'hFF;
   localparam logic [7:0] ADDR_MAX_MODBUS = 8'hF7;

   typedef enum logic [1:0] {
      COAST_DIN, COAST_SERIAL, COAST_AND, COAST_OR
   } dscm_coast_e;
   localparam dscm_coast_e COAST_SEL_RST = COAST_OR;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

//--- src/dscm_div_if.sv
`timescale 1ns/1ps
interface dscm_div_if;
   logic start;
   logic [29:0] dividend;
   logic [15:0] divisor;
   logic busy;
   logic done;
   logic [29:0] quotient;
   modport master (output start, output dividend, output divisor,
                   input busy, input done, input quotient);
   modport engine (input start, input dividend, input divisor,
                   output busy, output done, output quotient);
endinterface

//--- src/dscm_divider.sv
`timescale 1ns/1ps
module dscm_divider
   import dscm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   dscm_div_if.engine div
);
   typedef enum logic {DV_IDLE, DV_RUN} dscm_dv_e;
   dscm_dv_e st_q, st_d;
   logic [16:0] rem_q, rem_d;
   logic [29:0] quo_q, quo_d, res_q, res_d;
   logic [15:0] dsr_q, dsr_d;
   logic [4:0] cnt_q, cnt_d;
   logic done_q, done_d;
   logic [16:0] rem_sh;

   // ------------------------------------------------------------
   // Restoring division, one quotient bit per clock
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      rem_d = rem_q;
      quo_d = quo_q;
      res_d = res_q;
      dsr_d = dsr_q;
      cnt_d = cnt_q;
      done_d = 1'b0;
      rem_sh = {rem_q[15:0], quo_q[29]};
      case (st_q)
         DV_IDLE: begin
            if (div.start) begin
               st_d = DV_RUN;
               rem_d = '0;
               quo_d = div.dividend;
               dsr_d = div.divisor;
               cnt_d = '0;
            end
         end
         default: begin
            if (rem_sh >= {1'b0, dsr_q}) begin
               rem_d = rem_sh - {1'b0, dsr_q};
               quo_d = {quo_q[28:0], 1'b1};
            end else begin
               rem_d = rem_sh;
               quo_d = {quo_q[28:0], 1'b0};
            end
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'h1D) begin
               st_d = DV_IDLE;
               res_d = quo_d;
               done_d = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= DV_IDLE;
         rem_q <= '0;
         quo_q <= '0;
         res_q <= '0;
         dsr_q <= '0;
         cnt_q <= '0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         rem_q <= rem_d;
         quo_q <= quo_d;
         res_q <= res_d;
         dsr_q <= dsr_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end

   assign div.busy = (st_q == DV_RUN);
   assign div.done = done_q;
   assign div.quotient = res_q;
endmodule

//--- verification/dscm_assertions.sv
`timescale 1ns/1ps
module dscm_assertions
   import dscm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic local_set,
   input wire logic motor_run,
   input wire logic [1:0] protocol,
   input wire logic [7:0] station_addr,
   input wire logic [2:0] baud_code,
   input wire logic local_reject
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ----
   // Bus answers
   // ----
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("awready during response");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready during response");
   // ----
   // Link settings
   // ----
   proto_code_a: assert property (protocol != 2'h2)
      else $error("invalid protocol");
   addr_range_a: assert property (
      (protocol == PROTO_NATIVE && station_addr <= ADDR_MAX_NATIVE) ||
      (protocol == PROTO_BUILDING && station_addr != 8'h00) ||
      (protocol == PROTO_MODBUS && station_addr != 8'h00 &&
       station_addr <= ADDR_MAX_MODBUS)) else $error("station range");
   baud_range_a: assert property (baud_code <= BAUD_MAX)
      else $error("baud code range");
   reject_keep_a: assert property (local_reject |->
      $past(local_set) && $stable(station_addr) && $stable(baud_code)
      ##1 !local_reject) else $error("refused preset applied");
   cover property (local_reject);
   cover property ($rose(motor_run));
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind dscm_top dscm_assertions dscm_assertions_inst (.ref_clk, .resetn,
   .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .local_set,
   .motor_run, .protocol, .station_addr, .baud_code, .local_reject);

//--- verification/dscm_local_unit.sv
`timescale 1ns/1ps
module dscm_local_unit (
   input wire logic ref_clk,
   output logic local_set,
   output logic [1:0] local_protocol,
   output logic [7:0] local_station,
   output logic [2:0] local_baud
);
   initial begin
      local_set = 1'b0;
      local_protocol = 2'h0;
      local_station = 8'h00;
      local_baud = 3'h0;
   end
   // One-cycle preset; the station field changes again so stale values are not reused
   task automatic preset(input logic [1:0] p, input logic [7:0] s,
                         input logic [2:0] b);
      @(posedge ref_clk);
      local_set <= 1'b1;
      local_protocol <= p;
      local_station <= s;
      local_baud <= b;
      @(posedge ref_clk);
      local_set <= 1'b0;
      local_station <= ~s;
   endtask
endmodule

//--- verification/tb_drive_serial_command_merge.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
   err_count++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb_drive_serial_command_merge import dscm_pkg::*;;
   logic ref_clk = 1'b0, resetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, coast_in_n = 1'b1;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp, local_protocol, protocol;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, local_set, motor_run, ref_reverse, local_reject;
   logic [7:0] local_station, station_addr;
   logic [2:0] local_baud, baud_code;
   logic [15:0] act_freq = 16'h0, baud_div, lf = 16'h003B;
   logic act_reverse = 1'b0;
   logic [18:0] ref_value;
   int err_count = 0, check_count = 0, cyc = 0;
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   dscm_top dscm_top_inst (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .coast_in_n, .local_set,
      .local_protocol, .local_station, .local_baud, .act_freq, .act_reverse,
      .motor_run, .ref_value, .ref_reverse, .protocol, .station_addr,
      .baud_code, .baud_div, .local_reject);
   dscm_local_unit local_unit_inst (.ref_clk, .local_set, .local_protocol,
      .local_station, .local_baud);
   // ----
   // Bus tasks and expectations
   // ----
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic run_exp(input int m, input logic i, s);
      return m == 0 ? i : m == 1 ? s : m == 2 ? (i | s) : (i & s);
   endfunction
   function automatic logic [18:0] ref_exp(input logic [15:0] mn, mx, r);
      logic [16:0] g;
      g = r[15] ? {1'b0, ~r} + 17'h1 : {1'b0, r};
      if (mx <= mn) return 19'h0;
      return 19'(36'(mn) + ((36'(mx) - 36'(mn)) * 36'(g) >> 14));
   endfunction
   function automatic logic [15:0] frq_exp(input logic [15:0] f, lo, hi,
                                           input logic rv);
      logic [35:0] t;
      if (f <= lo || hi <= lo) return 16'h0;
      t = (36'(f - lo) << 14) / 36'(hi - lo);
      if (t > 36'h7FFF) t = 36'h7FFF;
      return rv ? 16'(~t + 36'h1) : 16'(t);
   endfunction
   task automatic complete_run;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Generous ceiling; the whole sequence needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end
   // ----
   // Main sequence
   // ----
   logic [31:0] d;
   logic [1:0] r;
   logic [15:0] v, mx, f[4];
   logic [17:0] pre[7];
   logic [7:0] es = 8'h01;
   logic [2:0] eb = 3'h5;
   logic [1:0] ep = 2'h0;
   initial begin
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(OFF_STATION, d, r); `CHK("station", 32'h1, d)
      rd(OFF_BAUD, d, r); `CHK("baud", 32'h5, d)
      rd(OFF_COAST_SEL, d, r); `CHK("coast sel", 32'h3, d)
      wr(OFF_STATION, 32'h22, r); `CHK("wr sta", RESP_SLVERR, r)
      wr(OFF_BAUD, 32'h1, r); `CHK("wr baud", RESP_SLVERR, r)
      rd(OFF_STATION, d, r); `CHK("sta kept", 32'h1, d)
      rd(OFF_BAUD, d, r); `CHK("baud kept", 32'h5, d)
      wr(8'h40, 32'h1, r); `CHK("wr hole", RESP_DECERR, r)
      rd(8'h40, d, r); `CHK("rd hole", RESP_DECERR, r)
      for (int m = 0; m < 4; m++) begin
         wr(OFF_COAST_SEL, 32'(m), r);
         for (int k = 0; k < 4; k++) begin
            coast_in_n <= k[1];
            wr(OFF_CTRL, {28'h0, k[0], 3'h0}, r);
            repeat (4) @(posedge ref_clk);
            `CHK("run", run_exp(m, k[1], k[0]), motor_run)
         end
      end
      wr(OFF_REF_MIN, 32'h64, r);
      mx = 16'h03E8;
      wr(OFF_REF_MAX, {16'h0, mx}, r);
      for (int k = 0; k < 8; k++) begin
         lf = lfsr(lf);
         v = k == 0 ? 16'h4000 : k == 1 ? 16'hE000 : k == 2 ? 16'h8000 : lf;
         if (k > 3) mx = lfsr(lf);
         if (k > 3) wr(OFF_REF_MAX, {16'h0, mx}, r);
         wr(OFF_SPEED_REF, {16'h0, v}, r);
         repeat (2) @(posedge ref_clk);
         `CHK("ref", ref_exp(16'h64, mx, v), ref_value)
         `CHK("reverse", v[15], ref_reverse)
      end
      // Slow frequency word path: fixed settle time per the hand-over
      f = '{16'h0019, 16'h0019, 16'h00C8, lf & 16'h003F};
      for (int k = 0; k < 4; k++) begin
         act_freq <= f[k];
         act_reverse <= k[0];
         repeat (70) @(posedge ref_clk);
         rd(OFF_FREQ_WORD, d, r);
         `CHK("freq", frq_exp(f[k], 16'h0, 16'h32, k[0]), d[15:0])
      end
      pre = '{{2'h0, 8'hC8, 3'h2, 5'h1}, {2'h1, 8'h00, 3'h4, 5'h0},
             {2'h2, 8'h05, 3'h5, 5'h0}, {2'h3, 8'hF8, 3'h1, 5'h0},
             {2'h0, 8'h09, 3'h6, 5'h0}, {2'h1, 8'hFF, 3'h0, 5'h1},
             {2'h3, 8'h01, 3'h5, 5'h1}};
      for (int k = 0; k < 7; k++) begin
         local_unit_inst.preset(pre[k][17:16], pre[k][15:8], pre[k][7:5]);
         @(posedge ref_clk);
         `CHK("reject", ~pre[k][0], local_reject)
         if (pre[k][0]) {ep, es, eb} = pre[k][17:5];
         repeat (2) @(posedge ref_clk);
         `CHK("station", es, station_addr)
         `CHK("protocol", ep, protocol)
         `CHK("baud code", eb, baud_code)
         `CHK("baud div", 16'(CLK_HZ / BAUD_RATE[eb]), baud_div)
         rd(OFF_BAUD, d, r); `CHK("baud rd", {29'h0, eb}, d)
      end
      complete_run();
   end
endmodule
